/* gio_pkg.sv */
/*
 * Shared constants, field layouts and carrier types for the global I/O pin
 * control block.
 * Assumes a single 200 MHz clock domain and 32-bit AHB-Lite register access.
 */
package gio_pkg;

    localparam int GIO_PINS = 30;
    localparam int GIO_ADDR_W = 8;

    // register byte offsets inside the block window
    localparam logic [7:0] GIO_OFS_TAKEOVER = 8'h00;
    localparam logic [7:0] GIO_OFS_DIR = 8'h04;
    localparam logic [7:0] GIO_OFS_OPEN_DRAIN = 8'h08;
    localparam logic [7:0] GIO_OFS_OUT_VALUE = 8'h0c;
    localparam logic [7:0] GIO_OFS_PIN_LEVEL = 8'h10;
    localparam logic [7:0] GIO_OFS_FUNC_SEL = 8'h14;
    localparam logic [7:0] GIO_OFS_VALUE_SET = 8'h18;
    localparam logic [7:0] GIO_OFS_VALUE_CLR = 8'h1c;
    localparam logic [7:0] GIO_OFS_DRIVE_STAT = 8'h20;

    // reset values
    localparam logic [29:0] GIO_RST_TAKEOVER = 30'h0000_0000;
    localparam logic [29:0] GIO_RST_DIR = 30'h0000_0000;
    localparam logic [29:0] GIO_RST_OPEN_DRAIN = 30'h0000_0000;
    localparam logic [29:0] GIO_RST_OUT_VALUE = 30'h0000_0000;
    localparam logic [29:0] GIO_RST_FUNC_SEL = 30'h0000_0000;

    // fixed bit position of every pin function in each 30-bit field
    localparam int GIO_BIT_PWM0A = 0;
    localparam int GIO_BIT_PWM0B = 1;
    localparam int GIO_BIT_PWM1A = 2;
    localparam int GIO_BIT_PWM1B = 3;
    localparam int GIO_BIT_PWM2A = 4;
    localparam int GIO_BIT_PWM2B = 5;
    localparam int GIO_BIT_PWM3A = 6;
    localparam int GIO_BIT_PWM3B = 7;
    localparam int GIO_BIT_SYNC = 8;
    localparam int GIO_BIT_FAULT0 = 9;
    localparam int GIO_BIT_FAULT1 = 10;
    localparam int GIO_BIT_FAULT2 = 11;
    localparam int GIO_BIT_EXT_INT = 12;
    localparam int GIO_BIT_ALERT = 13;
    localparam int GIO_BIT_CONTROL = 14;
    localparam int GIO_BIT_BUS_DATA = 15;
    localparam int GIO_BIT_BUS_CLK = 16;
    localparam int GIO_BIT_TMR_PWM0 = 17;
    localparam int GIO_BIT_TMR_PWM1 = 18;
    localparam int GIO_BIT_TMR_CAP = 19;
    localparam int GIO_BIT_UART_RX0 = 20;
    localparam int GIO_BIT_UART_RX1 = 21;
    localparam int GIO_BIT_UART_TX0 = 22;
    localparam int GIO_BIT_UART_TX1 = 23;
    localparam int GIO_BIT_JTAG_TDI = 24;
    localparam int GIO_BIT_JTAG_TMS = 25;
    localparam int GIO_BIT_JTAG_TDO = 26;
    localparam int GIO_BIT_JTAG_TCK = 27;
    localparam int GIO_BIT_ADC_TRIG = 28;
    localparam int GIO_BIT_FAULT3 = 29;

    typedef struct packed {
        logic [29:0] takeover;
        logic [29:0] dir;
        logic [29:0] open_drain;
        logic [29:0] out_value;
        logic [29:0] func_sel;
    } gio_cfg_t;

    typedef struct packed {
        logic out;
        logic oe;
    } gio_drive_t;

    typedef struct packed {
        logic act;
        logic wr;
        logic [7:0] ofs;
    } gio_bus_t;

    typedef struct packed {
        gio_cfg_t cfg;
        gio_bus_t bus;
        logic [31:0] rdata;
        logic [29:0] sync1;
        logic [29:0] sync2;
        logic [29:0] pad_out;
        logic [29:0] pad_oe;
    } gio_state_t;

endpackage : gio_pkg

/* gio_pin_cell.sv */
/*
 * One pin's drive selection: peripheral or global control, and push-pull
 * or open-drain shaping of the global drive.
 * Assumes its caller registers the result before it reaches the pad.
 */
`timescale 1ns/100ps
module gio_pin_cell
    import gio_pkg::*;
(
    input wire logic takeover,
    input wire logic func_sel,
    input wire gio_drive_t prim,
    input wire gio_drive_t alt,
    input wire logic dir,
    input wire logic open_drain,
    input wire logic out_value,
    output gio_drive_t drive
);
    gio_drive_t periph;

    always_comb begin
        // only one of the sharing functions ever reaches the pad
        periph = func_sel ? alt : prim;
        if (takeover) begin
            if (open_drain) begin
                // low pulls, high releases the line
                drive.out = 1'b0;
                drive.oe = dir & ~out_value;
            end else begin
                drive.out = out_value;
                drive.oe = dir;
            end
        end else begin
            drive = periph;
        end
    end

endmodule : gio_pin_cell

/* gio_global_io.sv */
/*
 * Global I/O pin control: AHB-Lite register slave, per-pin takeover of
 * thirty digital pins from their peripherals, direction, level, open-drain
 * and function selection, and synchronised pin level readback.
 * Assumes pads resolve PAD_OUT/PAD_OE outside, PAD_IN is asynchronous, and
 * peripheral drive signals are on CLK.
 */
`timescale 1ns/100ps
module gio_global_io
    import gio_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    input wire logic [29:0] PRI_OUT,
    input wire logic [29:0] PRI_OE,
    input wire logic [29:0] ALT_OUT,
    input wire logic [29:0] ALT_OE,
    output logic [29:0] PRI_IN,
    output logic [29:0] ALT_IN,
    input wire logic [29:0] PAD_IN,
    output logic [29:0] PAD_OUT,
    output logic [29:0] PAD_OE
);

    gio_state_t s_reg;
    gio_state_t s_next;
    gio_drive_t cell_drive [GIO_PINS];
    wire logic [29:0] drive_out;
    wire logic [29:0] drive_oe;

    // true when the address lies in the block window and on a word boundary
    function automatic logic gio_in_window(input logic [31:0] addr);
        gio_in_window = (addr[31:GIO_ADDR_W] == 24'h00_0000) && (addr[1:0] == 2'h0);
    endfunction : gio_in_window

    // read mux shared by the address-phase capture path
    function automatic logic [31:0] gio_read_word(
        input logic [7:0] ofs,
        input gio_cfg_t cfg,
        input logic [29:0] level,
        input logic [29:0] oe
    );
        logic [29:0] field;
        field = 30'h0000_0000;
        unique case (ofs)
            GIO_OFS_TAKEOVER: field = cfg.takeover;
            GIO_OFS_DIR: field = cfg.dir;
            GIO_OFS_OPEN_DRAIN: field = cfg.open_drain;
            GIO_OFS_OUT_VALUE: field = cfg.out_value;
            GIO_OFS_VALUE_SET: field = cfg.out_value;
            GIO_OFS_VALUE_CLR: field = cfg.out_value;
            GIO_OFS_PIN_LEVEL: field = level;
            GIO_OFS_FUNC_SEL: field = cfg.func_sel;
            GIO_OFS_DRIVE_STAT: field = oe;
            default: field = 30'h0000_0000;
        endcase
        gio_read_word = {2'h0, field};
    endfunction : gio_read_word

    // the vectors hold only digital pins; reset, supplies and analog
    // inputs have no position and so can never be taken over
    genvar gi;
    generate
        for (gi = 0; gi < GIO_PINS; gi++) begin : g_pin
            gio_pin_cell u_cell (
                .takeover(s_reg.cfg.takeover[gi]),
                .func_sel(s_reg.cfg.func_sel[gi]),
                .prim({PRI_OUT[gi], PRI_OE[gi]}),
                .alt({ALT_OUT[gi], ALT_OE[gi]}),
                .dir(s_reg.cfg.dir[gi]),
                .open_drain(s_reg.cfg.open_drain[gi]),
                .out_value(s_reg.cfg.out_value[gi]),
                .drive(cell_drive[gi])
            );
            assign drive_out[gi] = cell_drive[gi].out;
            assign drive_oe[gi] = cell_drive[gi].oe;
        end
    endgenerate

    always_comb begin
        s_next = s_reg;

        // pad levels pass two flops before anything reads them
        s_next.sync1 = PAD_IN;
        s_next.sync2 = s_reg.sync1;

        // data phase of a write captured in the previous cycle
        if (s_reg.bus.act && s_reg.bus.wr) begin
            unique case (s_reg.bus.ofs)
                GIO_OFS_TAKEOVER: begin
                    // clearing a bit leaves dir, value and drive type alone
                    s_next.cfg.takeover = HWDATA[29:0];
                end
                GIO_OFS_DIR: begin
                    s_next.cfg.dir = HWDATA[29:0];
                end
                GIO_OFS_OPEN_DRAIN: begin
                    s_next.cfg.open_drain = HWDATA[29:0];
                end
                GIO_OFS_OUT_VALUE: begin
                    s_next.cfg.out_value = HWDATA[29:0];
                end
                GIO_OFS_VALUE_SET: begin
                    // set/clear aliases avoid read-modify-write races
                    s_next.cfg.out_value = s_reg.cfg.out_value | HWDATA[29:0];
                end
                GIO_OFS_VALUE_CLR: begin
                    s_next.cfg.out_value = s_reg.cfg.out_value & ~HWDATA[29:0];
                end
                GIO_OFS_FUNC_SEL: begin
                    s_next.cfg.func_sel = HWDATA[29:0];
                end
                default: begin
                    // level, drive status and unmapped words ignore writes
                end
            endcase
        end

        // address phase; a read of a stored setting sees any write committing this same cycle, drive status lags it
        s_next.bus.act = HSEL && HTRANS[1] && HREADY && gio_in_window(HADDR);
        s_next.bus.wr = HWRITE;
        s_next.bus.ofs = HADDR[7:0];
        if (HSEL && HTRANS[1] && HREADY) begin
            if (!HWRITE && gio_in_window(HADDR)) begin
                s_next.rdata = gio_read_word(HADDR[7:0], s_next.cfg, s_reg.sync2,
                    s_reg.pad_oe);
            end else begin
                s_next.rdata = 32'h0000_0000;
            end
        end

        // pad drive is registered; a takeover change reaches the pad
        // one edge after the edge that ends the write's data phase
        s_next.pad_out = drive_out;
        s_next.pad_oe = drive_oe;
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s_reg.cfg.takeover <= GIO_RST_TAKEOVER;
            s_reg.cfg.dir <= GIO_RST_DIR;
            s_reg.cfg.open_drain <= GIO_RST_OPEN_DRAIN;
            s_reg.cfg.out_value <= GIO_RST_OUT_VALUE;
            s_reg.cfg.func_sel <= GIO_RST_FUNC_SEL;
            s_reg.bus <= '0;
            s_reg.rdata <= 32'h0000_0000;
            s_reg.sync1 <= 30'h0000_0000;
            s_reg.sync2 <= 30'h0000_0000;
            s_reg.pad_out <= 30'h0000_0000;
            s_reg.pad_oe <= 30'h0000_0000;
        end else begin
            s_reg <= s_next;
        end
    end

    // zero wait state slave, every answer OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = s_reg.rdata;

    assign PAD_OUT = s_reg.pad_out;
    assign PAD_OE = s_reg.pad_oe;

    // peripherals keep their own local control and see the pin level only
    // while they are its selected function and it is not taken over
    assign PRI_IN = s_reg.sync2 & ~s_reg.cfg.func_sel & ~s_reg.cfg.takeover;
    assign ALT_IN = s_reg.sync2 & s_reg.cfg.func_sel & ~s_reg.cfg.takeover;

endmodule : gio_global_io

/* gio_global_io_sva.sv */
/*
 * Port-level checker for the global I/O pin control block.
 * Assumes HREADY is tied to HREADYOUT and a single clock domain.
 */
`timescale 1ns/100ps
module gio_global_io_sva
    import gio_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [31:0] HRDATA,
    input wire logic [29:0] PRI_OUT,
    input wire logic [29:0] PRI_OE,
    input wire logic [29:0] ALT_OUT,
    input wire logic [29:0] ALT_OE,
    input wire logic [29:0] PRI_IN,
    input wire logic [29:0] ALT_IN,
    input wire logic [29:0] PAD_IN,
    input wire logic [29:0] PAD_OUT,
    input wire logic [29:0] PAD_OE
);
    logic wr;
    logic take;
    logic touched_reg;
    assign take = HSEL & HTRANS[1] & HREADY;
    assign wr = take & HWRITE;
    // conservative: any write ends the plain pass-through check
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            touched_reg <= 1'b0;
        end else if (wr) begin
            touched_reg <= 1'b1;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    AST_HRESP_OKAY: assert property (HRESP == 1'b0)
        else $error("slave response not okay");
    AST_ZERO_WAIT: assert property (take |=> HREADYOUT)
        else $error("data phase stretched");
    AST_RDATA_TOP: assert property (take && !HWRITE |=> HRDATA[31:30] == 2'b00)
        else $error("read data above pin range");
    AST_ONE_OWNER: assert property ((PRI_IN & ALT_IN) == 30'h0)
        else $error("pin level given to two functions");
    AST_IN_FROM_PAD: assert property (
        ((PRI_IN | ALT_IN) & ~$past(PAD_IN, 2) & ~$past(PAD_IN, 3)) == 30'h0)
        else $error("peripheral input not from pad");
    AST_RESET_PERIPH: assert property ($past(RESETN) && !touched_reg |->
        PAD_OUT == $past(PRI_OUT) && PAD_OE == $past(PRI_OE))
        else $error("pad not under peripheral control");
    AST_ALT_IDLE: assert property (!touched_reg |-> ALT_IN == 30'h0)
        else $error("alternate input active at reset");
    AST_PAD_HOLD: assert property ($past(RESETN) && !$past(wr) && !$past(wr, 2)
        && $stable(PRI_OUT) && $stable(PRI_OE) && $stable(ALT_OUT) && $stable(ALT_OE)
        |=> $stable(PAD_OUT) && $stable(PAD_OE))
        else $error("pad changed without cause");
    AST_RDATA_HOLD: assert property (!take |=> $stable(HRDATA))
        else $error("read data changed while idle");
endmodule : gio_global_io_sva

bind gio_global_io gio_global_io_sva gio_global_io_sva_i (.CLK(CLK), .RESETN(RESETN),
    .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .HRDATA(HRDATA), .PRI_OUT(PRI_OUT), .PRI_OE(PRI_OE), .ALT_OUT(ALT_OUT),
    .ALT_OE(ALT_OE), .PRI_IN(PRI_IN), .ALT_IN(ALT_IN), .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT),
    .PAD_OE(PAD_OE));

/* gio_global_io_tb.sv */
/*
 * Self-checking bench for the global I/O pin control block, with a vector model.
 * Assumes zero-wait AHB-Lite slave; tasks are entered right after a rising edge.
 */
`timescale 1ns/100ps
module gio_global_io_tb
    import gio_pkg::*;
;
    logic CLK = 1'b0, RESETN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, HRESP, HREADYOUT;
    logic [1:0] HTRANS = 2'b00;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
    logic [29:0] PRI_OUT = 30'h0, PRI_OE = 30'h0, ALT_OUT = 30'h0, ALT_OE = 30'h0;
    logic [29:0] PAD_IN = 30'h0, PRI_IN, ALT_IN, PAD_OUT, PAD_OE;
    logic [29:0] tk, dr, od, ov, fs, m, eo, ep;
    int err_total = 0, num_checks = 0, cyc = 0;

    gio_global_io gio_global_io_i (.CLK(CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
        .PRI_OUT(PRI_OUT), .PRI_OE(PRI_OE), .ALT_OUT(ALT_OUT), .ALT_OE(ALT_OE),
        .PRI_IN(PRI_IN), .ALT_IN(ALT_IN), .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE));

    initial forever #2.5 CLK = ~CLK;

    task automatic report_and_stop;
        if (err_total == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // a hung handshake ends here rather than in the simulator's own limit
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        HSEL <= 1'b1;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        HTRANS <= 2'b10;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'b00;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask : xfer

    task automatic do_reset;
        RESETN <= 1'b0;
        repeat (8) @(posedge CLK);
        RESETN <= 1'b1;
        {tk, dr, od, ov, fs} = '0;
    endtask : do_reset

    task automatic check_all;
        logic [7:0] ofs [10];
        logic [31:0] ex [10];
        repeat (4) @(posedge CLK);
        eo = (tk & dr & ~(od & ov)) | (~tk & ((fs & ALT_OE) | (~fs & PRI_OE)));
        ep = (tk & ~od & ov) | (~tk & ((fs & ALT_OUT) | (~fs & PRI_OUT)));
        chk("pad_out", {2'h0, PAD_OUT}, {2'h0, ep});
        chk("pad_oe", {2'h0, PAD_OE}, {2'h0, eo});
        chk("pri_in", {2'h0, PRI_IN}, {2'h0, PAD_IN & ~tk & ~fs});
        chk("alt_in", {2'h0, ALT_IN}, {2'h0, PAD_IN & ~tk & fs});
        ofs = '{GIO_OFS_TAKEOVER, GIO_OFS_DIR, GIO_OFS_OPEN_DRAIN, GIO_OFS_OUT_VALUE,
            GIO_OFS_FUNC_SEL, GIO_OFS_PIN_LEVEL, GIO_OFS_VALUE_SET, GIO_OFS_VALUE_CLR,
            GIO_OFS_DRIVE_STAT, 8'h24};
        ex = '{{2'h0, tk}, {2'h0, dr}, {2'h0, od}, {2'h0, ov}, {2'h0, fs}, {2'h0, PAD_IN},
            {2'h0, ov}, {2'h0, ov}, {2'h0, eo}, 32'h0};
        for (int k = 0; k < 10; k++) begin
            xfer(ofs[k], 1'b0, 32'h0);
            chk("readback", rd, ex[k]);
        end
    endtask : check_all

    initial begin
        void'($urandom(32'h22829bb0));
        do_reset();
        check_all();
        for (int i = 0; i < 24; i++) begin
            PRI_OUT <= 30'($urandom);
            PRI_OE <= 30'($urandom);
            ALT_OUT <= 30'($urandom);
            ALT_OE <= 30'($urandom);
            PAD_IN <= 30'($urandom);
            tk = i[0] ? 30'($urandom) : (i[1] ? '1 : '0);
            dr = 30'($urandom);
            od = 30'($urandom);
            ov = 30'($urandom);
            fs = 30'($urandom);
            xfer(GIO_OFS_TAKEOVER, 1'b1, {2'b00, tk});
            xfer(GIO_OFS_DIR, 1'b1, {2'b00, dr});
            xfer(GIO_OFS_OPEN_DRAIN, 1'b1, {2'b00, od});
            xfer(GIO_OFS_OUT_VALUE, 1'b1, {2'b00, ov});
            xfer(GIO_OFS_FUNC_SEL, 1'b1, {2'b00, fs});
            m = 30'($urandom);
            xfer(GIO_OFS_VALUE_SET, 1'b1, {2'b00, m});
            ov = ov | m;
            m = 30'($urandom);
            xfer(GIO_OFS_VALUE_CLR, 1'b1, {2'b00, m});
            ov = ov & ~m;
            // read-only and unmapped places must swallow writes
            xfer(GIO_OFS_PIN_LEVEL, 1'b1, '1);
            xfer(GIO_OFS_DRIVE_STAT, 1'b1, '1);
            xfer(8'h24, 1'b1, '1);
            check_all();
        end
        // dropping takeover hands pins back but keeps the stored settings
        xfer(GIO_OFS_TAKEOVER, 1'b1, 32'h0000_0000);
        tk = '0;
        check_all();
        do_reset();
        check_all();
        report_and_stop();
    end
endmodule : gio_global_io_tb
